// [sofc_defs.svh]
// Offsets, field positions, reset values and timing counts of the serial output block.
// Included by bare name from the design modules, the checker and the bench (not the package or receiver model); holds macros only.
`ifndef SOFC_DEFS_SVH
`define SOFC_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SOFC_ADDR_PHASE   8'h42
`define SOFC_ADDR_MODE    8'h46
`define SOFC_ADDR_WLEN    8'h53
`define SOFC_ADDR_TRIM    8'h55
`define SOFC_ADDR_RATE    8'h56
`define SOFC_ADDR_STATUS  8'h57

// ****************************************************************
// Field positions
// ****************************************************************
`define SOFC_PHASE_LSB    5
`define SOFC_BTC_BIT      2
`define SOFC_MSBF_BIT     3
`define SOFC_SDR_BIT      4
`define SOFC_FALL_BIT     13
`define SOFC_WLEN_LSB     0
`define SOFC_TRIM_LSB     0
`define SOFC_RATE_LSB     0
`define SOFC_ST_DONE_BIT  0
`define SOFC_ST_RUN_BIT   1
`define SOFC_ST_SDR_BIT   2
`define SOFC_ST_WIDE_BIT  3

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define SOFC_PHASE_RST    2'h2
`define SOFC_WLEN_RST     2'h0
`define SOFC_WLEN_14      2'h2
`define SOFC_TRIM_RST     6'h20
`define SOFC_RATE_RST     2'h0
`define SOFC_LAST_BIT_12  4'hb
`define SOFC_LAST_BIT_14  4'hd
`define SOFC_FCLK_HIGH_12 4'h6
`define SOFC_FCLK_HIGH_14 4'h7

// ****************************************************************
// Timing: startup time and input rates, counts in sample clock edges
// ****************************************************************
`define SOFC_STARTUP_NS   15000
`define SOFC_RATE0_MHZ    65
`define SOFC_RATE1_MHZ    45
`define SOFC_RATE2_MHZ    30
`define SOFC_RATE3_MHZ    20
`define SOFC_START_CNT(mhz) ((`SOFC_STARTUP_NS * (mhz) + 999) / 1000)

`endif

// [sofc_pkg.sv]
// Types shared by the serial output block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package sofc_pkg;

  // ****************************************************************
  // Link state
  // ****************************************************************
  typedef enum logic [2:0] {
    SOFC_IDLE  = 3'b001,
    SOFC_START = 3'b010,
    SOFC_RUN   = 3'b100
  } sofc_state_e;

  typedef logic [12:0] sofc_conv_t;
  typedef logic [13:0] sofc_word_t;

endpackage : sofc_pkg

`default_nettype wire

// [sofc_startup.sv]
// Startup counter: counts sample clock edges after power-up.
// Assumes a one-cycle edge pulse from a synchronised sample clock.
`default_nettype none
`include "sofc_defs.svh"

module sofc_startup
  import sofc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       restart,
  input  wire logic       sample_edge,
  input  wire logic [1:0] rate_class,
  output logic            done
);

  logic [9:0] count;
  logic [9:0] limit;
  logic [9:0] limit0;
  logic [9:0] limit1;
  logic [9:0] limit2;
  logic [9:0] limit3;
  logic       reached;

  // Higher rate class codes select slower clocks and need fewer edges for the same fixed settling time
  assign limit0  = 10'(`SOFC_START_CNT(`SOFC_RATE0_MHZ));
  assign limit1  = 10'(`SOFC_START_CNT(`SOFC_RATE1_MHZ));
  assign limit2  = 10'(`SOFC_START_CNT(`SOFC_RATE2_MHZ));
  assign limit3  = 10'(`SOFC_START_CNT(`SOFC_RATE3_MHZ));
  assign limit   = (rate_class == 2'h0) ? limit0 :
                   (rate_class == 2'h1) ? limit1 :
                   (rate_class == 2'h2) ? limit2 : limit3;
  assign reached = (count >= limit);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count <= 10'h000;
      done  <= 1'b0;
    end else if (restart) begin
      count <= 10'h000;
      done  <= 1'b0;
    end else begin
      if (sample_edge && !reached) begin
        count <= count + 10'h001;
      end
      done <= reached;
    end
  end

endmodule : sofc_startup

`default_nettype wire

// [sofc_lane.sv]
// One serial data lane: shapes a conversion word and emits one bit per window.
// Assumes load, settings and bit index come from the frame engine on the same clock.
`default_nettype none
`include "sofc_defs.svh"

module sofc_lane
  import sofc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       load,
  input  wire sofc_conv_t conv_word,
  input  wire logic       twos,
  input  wire logic       wide,
  input  wire logic       msb_first,
  input  wire logic       running,
  input  wire logic [3:0] bit_idx,
  output logic            serial_bit
);

  sofc_word_t word;
  sofc_conv_t coded;
  sofc_word_t shaped;
  logic [3:0] last;
  logic [3:0] pos;

  assign coded  = {conv_word[12] ^ twos, conv_word[11:0]};
  assign shaped = wide ? {coded, 1'b0}
                       : {2'b00, coded[12:1]};
  assign last   = wide ? `SOFC_LAST_BIT_14 : `SOFC_LAST_BIT_12;
  assign pos    = msb_first ? (last - bit_idx) : bit_idx;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      word       <= 14'h0000;
      serial_bit <= 1'b0;
    end else begin
      if (load) begin
        word <= shaped;
      end
      serial_bit <= running ? word[pos] : 1'b0;
    end
  end

endmodule : sofc_lane

`default_nettype wire

// [sofc_top.sv]
// Serial output formatting and configuration for an eight lane converter link.
// Assumes conversion words on the same clock; sample clock and power down arrive as pins.
`default_nettype none
`include "sofc_defs.svh"

module sofc_top
  import sofc_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [15:0]  reg_wdata,
  input  wire logic         reg_write,
  input  wire logic         reg_read,
  output logic [15:0]       reg_rdata,
  input  wire logic         sample_clock_pin,
  input  wire logic         power_down_pin,
  input  wire logic [103:0] conv_data,
  input  wire logic         conv_valid,
  output logic              bit_clock_out,
  output logic              frame_clock_pos,
  output logic [7:0]        serial_data,
  output logic [5:0]        full_scale_trim,
  output logic              startup_done
);

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [1:0]  bit_clock_phase;
  logic        twos_complement_select;
  logic        high_bit_leads;
  logic        single_edge_select;
  logic        falling_edge_center;
  logic [1:0]  serial_word_length;
  logic [1:0]  input_rate_class;

  logic        wr_phase;
  logic        wr_mode;
  logic        wr_wlen;
  logic        wr_trim;
  logic        wr_rate;

  assign wr_phase = reg_write && (reg_addr == `SOFC_ADDR_PHASE);
  assign wr_mode  = reg_write && (reg_addr == `SOFC_ADDR_MODE);
  assign wr_wlen  = reg_write && (reg_addr == `SOFC_ADDR_WLEN);
  assign wr_trim  = reg_write && (reg_addr == `SOFC_ADDR_TRIM);
  assign wr_rate  = reg_write && (reg_addr == `SOFC_ADDR_RATE);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bit_clock_phase <= `SOFC_PHASE_RST;
    end else if (wr_phase) begin
      bit_clock_phase <= reg_wdata[`SOFC_PHASE_LSB +: 2];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      twos_complement_select <= 1'b0;
      high_bit_leads         <= 1'b0;
      single_edge_select     <= 1'b0;
      falling_edge_center    <= 1'b0;
    end else if (wr_mode) begin
      twos_complement_select <= reg_wdata[`SOFC_BTC_BIT];
      high_bit_leads         <= reg_wdata[`SOFC_MSBF_BIT];
      single_edge_select     <= reg_wdata[`SOFC_SDR_BIT];
      falling_edge_center    <= reg_wdata[`SOFC_FALL_BIT];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      serial_word_length <= `SOFC_WLEN_RST;
      full_scale_trim    <= `SOFC_TRIM_RST;
      input_rate_class   <= `SOFC_RATE_RST;
    end else begin
      if (wr_wlen) begin
        serial_word_length <= reg_wdata[`SOFC_WLEN_LSB +: 2];
      end
      if (wr_trim) begin
        full_scale_trim <= reg_wdata[`SOFC_TRIM_LSB +: 6];
      end
      if (wr_rate) begin
        input_rate_class <= reg_wdata[`SOFC_RATE_LSB +: 2];
      end
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic sclk_meta;
  logic sclk_sync;
  logic sclk_prev;
  logic pd_meta;
  logic pd_sync;
  logic sample_edge;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sclk_meta <= 1'b0;
      sclk_sync <= 1'b0;
      sclk_prev <= 1'b0;
      pd_meta   <= 1'b1;
      pd_sync   <= 1'b1;
    end else begin
      sclk_meta <= sample_clock_pin;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
      pd_meta   <= power_down_pin;
      pd_sync   <= pd_meta;
    end
  end

  assign sample_edge = sclk_sync && !sclk_prev;

  // ****************************************************************
  // Power state and startup
  // ****************************************************************
  sofc_state_e state;
  sofc_state_e next_state;
  logic        start_done;
  logic        running;

  sofc_startup u_startup (
    .clock       (clock),
    .resetn      (resetn),
    .restart     (state == SOFC_IDLE),
    .sample_edge (sample_edge),
    .rate_class  (input_rate_class),
    .done        (start_done)
  );

  always_comb begin
    next_state = state;
    case (state)
      SOFC_IDLE: begin
        if (!pd_sync) begin
          next_state = SOFC_START;
        end
      end
      SOFC_START: begin
        if (pd_sync) begin
          next_state = SOFC_IDLE;
        end else if (start_done) begin
          next_state = SOFC_RUN;
        end
      end
      SOFC_RUN: begin
        if (pd_sync) begin
          next_state = SOFC_IDLE;
        end
      end
      default: begin
        next_state = SOFC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= SOFC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign running = (state == SOFC_RUN);

  // ****************************************************************
  // Frame engine
  // ****************************************************************
  // Each bit window is two clocks; double-edge bit clock spans two windows
  logic       half;
  logic [3:0] bit_idx;
  logic [3:0] last_bit;
  logic       frame_end;
  logic       frame_load;

  // Settings seen by the lanes and the clock outputs, frozen for a whole frame
  logic [1:0] frame_phase;
  logic       frame_twos;
  logic       frame_msbf;
  logic       frame_sdr;
  logic       frame_fall;
  logic       frame_wide;
  logic       cfg_wide;

  assign cfg_wide   = serial_word_length[1];
  assign last_bit   = frame_wide ? `SOFC_LAST_BIT_14 : `SOFC_LAST_BIT_12;
  assign frame_end  = running && half && (bit_idx == last_bit);
  assign frame_load = !running || frame_end;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      half    <= 1'b0;
      bit_idx <= 4'h0;
    end else if (!running) begin
      half    <= 1'b0;
      bit_idx <= 4'h0;
    end else begin
      half <= !half;
      if (half) begin
        bit_idx <= frame_end ? 4'h0 : bit_idx + 4'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      frame_phase <= `SOFC_PHASE_RST;
      frame_twos  <= 1'b0;
      frame_msbf  <= 1'b0;
      frame_sdr   <= 1'b0;
      frame_fall  <= 1'b0;
      frame_wide  <= 1'b0;
    end else if (frame_load) begin
      frame_phase <= bit_clock_phase;
      frame_twos  <= twos_complement_select;
      frame_msbf  <= high_bit_leads;
      frame_sdr   <= single_edge_select;
      frame_fall  <= falling_edge_center;
      frame_wide  <= cfg_wide;
    end
  end

  // ****************************************************************
  // Bit clock and frame clock
  // ****************************************************************
  logic [1:0] ddr_phase;
  logic       ddr_clk;
  logic       sdr_clk;
  logic       next_bit_clock;
  logic [3:0] fclk_high;
  logic       next_frame_clock;

  // Code 10 lines the edges up with the middle of each window
  assign ddr_phase        = {bit_idx[0], half} + frame_phase + 2'h3;
  assign ddr_clk          = ddr_phase[1];
  assign sdr_clk          = half ^ frame_fall;
  assign next_bit_clock   = running && (frame_sdr ? sdr_clk : ddr_clk);
  assign fclk_high        = frame_wide ? `SOFC_FCLK_HIGH_14 : `SOFC_FCLK_HIGH_12;
  assign next_frame_clock = running && (bit_idx < fclk_high);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bit_clock_out   <= 1'b0;
      frame_clock_pos <= 1'b0;
      startup_done    <= 1'b0;
    end else begin
      bit_clock_out   <= next_bit_clock;
      frame_clock_pos <= next_frame_clock;
      startup_done    <= start_done;
    end
  end

  // ****************************************************************
  // Sample holding and lanes
  // ****************************************************************
  // Latest conversion set; a frame takes whatever stands at its start
  logic [103:0] conv_hold;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      conv_hold <= 104'h0;
    end else if (conv_valid) begin
      conv_hold <= conv_data;
    end
  end

  for (genvar lane = 0; lane < 8; lane++) begin : g_lane
    sofc_lane u_lane (
      .clock      (clock),
      .resetn     (resetn),
      .load       (frame_load),
      .conv_word  (conv_hold[lane*13 +: 13]),
      .twos       (frame_twos),
      .wide       (frame_wide),
      .msb_first  (frame_msbf),
      .running    (running),
      .bit_idx    (bit_idx),
      .serial_bit (serial_data[lane])
    );
  end

  // ****************************************************************
  // Register read back
  // ****************************************************************
  logic [15:0] rd_phase;
  logic [15:0] rd_mode;
  logic [15:0] rd_wlen;
  logic [15:0] rd_trim;
  logic [15:0] rd_rate;
  logic [15:0] rd_status;
  logic [15:0] rd_mux;

  assign rd_phase  = 16'(bit_clock_phase) << `SOFC_PHASE_LSB;
  assign rd_mode   = (16'(twos_complement_select) << `SOFC_BTC_BIT)
                   | (16'(high_bit_leads) << `SOFC_MSBF_BIT)
                   | (16'(single_edge_select) << `SOFC_SDR_BIT)
                   | (16'(falling_edge_center) << `SOFC_FALL_BIT);
  assign rd_wlen   = 16'(serial_word_length) << `SOFC_WLEN_LSB;
  assign rd_trim   = 16'(full_scale_trim) << `SOFC_TRIM_LSB;
  assign rd_rate   = 16'(input_rate_class) << `SOFC_RATE_LSB;
  assign rd_status = (16'(start_done) << `SOFC_ST_DONE_BIT)
                   | (16'(running) << `SOFC_ST_RUN_BIT)
                   | (16'(frame_sdr) << `SOFC_ST_SDR_BIT)
                   | (16'(frame_wide) << `SOFC_ST_WIDE_BIT);
  assign rd_mux    = (reg_addr == `SOFC_ADDR_PHASE)  ? rd_phase  :
                     (reg_addr == `SOFC_ADDR_MODE)   ? rd_mode   :
                     (reg_addr == `SOFC_ADDR_WLEN)   ? rd_wlen   :
                     (reg_addr == `SOFC_ADDR_TRIM)   ? rd_trim   :
                     (reg_addr == `SOFC_ADDR_RATE)   ? rd_rate   :
                     (reg_addr == `SOFC_ADDR_STATUS) ? rd_status : 16'h0000;

  // Data valid only in the cycle after the strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_read ? rd_mux : 16'h0000;
    end
  end

endmodule : sofc_top

`default_nettype wire

// [sofc_top_sva.sv]
// Checker for the serial output block: register port and link framing.
// Assumes it is bound to sofc_top and sees only its ports.
`default_nettype none
`include "sofc_defs.svh"

module sofc_top_sva (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic        power_down_pin,
  input wire logic        bit_clock_out,
  input wire logic        frame_clock_pos,
  input wire logic [7:0]  serial_data,
  input wire logic [5:0]  full_scale_trim,
  input wire logic        startup_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  wire mapped = reg_addr inside {`SOFC_ADDR_PHASE, `SOFC_ADDR_MODE, `SOFC_ADDR_WLEN,
                                 `SOFC_ADDR_TRIM, `SOFC_ADDR_RATE, `SOFC_ADDR_STATUS};
  wire trim_wr   = reg_write && reg_addr == `SOFC_ADDR_TRIM;
  wire link_idle = !bit_clock_out && !frame_clock_pos && serial_data == 8'h00;
  logic [4:0] high_cnt;

  // Consecutive frame clock high cycles; saturates so a stuck clock never wraps back to a legal count
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      high_cnt <= 5'h00;
    end else if (!frame_clock_pos) begin
      high_cnt <= 5'h00;
    end else if (high_cnt != 5'h1f) begin
      high_cnt <= high_cnt + 5'h01;
    end
  end

  // ********************
  // Register port
  // ********************
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  unmapped_read_a: assert property (reg_read && !mapped |=> reg_rdata == 16'h0000)
    else $error("unmapped read returned data");
  trim_write_a: assert property (trim_wr |=> full_scale_trim == $past(reg_wdata[5:0]))
    else $error("trim output does not follow write");
  trim_hold_a: assert property (!trim_wr |=> $stable(full_scale_trim))
    else $error("trim output changed without write");
  trim_read_a: assert property (reg_read && reg_addr == `SOFC_ADDR_TRIM |=>
      reg_rdata == {10'h000, $past(full_scale_trim)})
    else $error("trim readback differs from trim output");

  // ********************
  // Link
  // ********************
  // Power down aborts frames, so framing checks stand aside while it is high
  link_quiet_a: assert property (!startup_done [*3] |-> link_idle)
    else $error("link active while not started");
  frame_high_a: assert property (disable iff (!resetn || power_down_pin)
      $fell(frame_clock_pos) |-> high_cnt == 5'h0c || high_cnt == 5'h0e)
    else $error("frame clock high phase wrong length");
  bit_window_a: assert property (disable iff (!resetn || power_down_pin)
      $rose(frame_clock_pos) |=> $stable(serial_data) ##2 $stable(serial_data))
    else $error("serial bit did not stand its window");
  startup_drop_a: assert property ($rose(power_down_pin) |-> ##[1:5] !startup_done)
    else $error("power down did not stop the link");
  startup_rise_a: assert property ($rose(startup_done) |->
      !power_down_pin && !$past(power_down_pin, 8))
    else $error("startup finished during power down");

  cover property ($rose(startup_done));
  cover property ($rose(frame_clock_pos));
  cover property (trim_wr);
endmodule : sofc_top_sva

bind sofc_top sofc_top_sva u_sva (.clock, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .power_down_pin, .bit_clock_out, .frame_clock_pos, .serial_data, .full_scale_trim,
  .startup_done);

`default_nettype wire

// [sofc_rx_model.sv]
// Receiving logic model: captures eight lanes with bit and frame clocks.
// Assumes the bench tells it the word length and the clocking mode.
`default_nettype none

module sofc_rx_model (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        bit_clock_out,
  input  wire logic        frame_clock_pos,
  input  wire logic [7:0]  serial_data,
  input  wire logic        sdr,
  input  wire logic        fall,
  input  wire logic        wide,
  output logic [7:0][13:0] word,
  output var int           frames
);
  timeunit 1ns;
  timeprecision 1ps;
  logic             bclk_q;
  logic             fclk_q;
  logic [3:0]       cnt;
  logic [7:0][13:0] sh;
  wire  [3:0]       nbits = wide ? 4'he : 4'hc;
  wire              rise  = !bclk_q && bit_clock_out;
  wire              fell  = bclk_q && !bit_clock_out;
  // Single-edge mode takes only the centred edge
  wire              take  = sdr ? (fall ? fell : rise) : (rise || fell);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bclk_q <= 1'b0;
      fclk_q <= 1'b0;
      cnt    <= 4'h0;
      sh     <= '0;
      word   <= '0;
      frames <= 0;
    end else begin
      bclk_q <= bit_clock_out;
      fclk_q <= frame_clock_pos;
      if (frame_clock_pos && !fclk_q) begin
        // Only complete frames count, so a torn first frame is never judged
        word   <= sh;
        frames <= frames + int'(cnt == nbits);
        sh     <= '0;
        cnt    <= 4'h0;
      end else if (take && cnt < nbits) begin
        for (int n = 0; n < 8; n++) sh[n][cnt] <= serial_data[n];
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : sofc_rx_model

`default_nettype wire

// [sofc_top_bench.sv]
// Self-checking bench for the serial output block.
// Assumes sofc_top, the receiver model and the bound checker.
`default_nettype none
`include "sofc_defs.svh"

module sofc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clock = 1'b0;
  logic             resetn = 1'b0;
  logic [7:0]       reg_addr = 8'h00;
  logic [15:0]      reg_wdata = 16'h0000;
  logic             reg_write = 1'b0;
  logic             reg_read = 1'b0;
  logic [15:0]      reg_rdata;
  logic             sample_clock_pin = 1'b0;
  logic             power_down_pin = 1'b1;
  logic [103:0]     conv_data = '0;
  logic             conv_valid = 1'b0;
  logic             bit_clock_out;
  logic             frame_clock_pos;
  logic [7:0]       serial_data;
  logic [5:0]       full_scale_trim;
  logic             startup_done;
  logic             sdr = 1'b0;
  logic             fall = 1'b0;
  logic             wide = 1'b0;
  logic [7:0][13:0] word;
  int               frames;
  int               errors = 0;
  int               compares = 0;
  logic [7:0]       ra [6] = '{8'h42, 8'h46, 8'h53, 8'h55, 8'h56, 8'h10};
  logic [15:0]      rv [6] = '{16'h0040, 16'h0000, 16'h0000, 16'h0020, 16'h0000, 16'h0000};
  logic [15:0]      wm [6] = '{16'h0060, 16'h201c, 16'h0003, 16'h003f, 16'h0003, 16'h0000};
  int               cnt [4] = '{975, 675, 450, 300};
  // Fall, single-edge, high first, two's complement; sample rate far below the limit
  logic [3:0]       cf [5] = '{4'b0000, 4'b0001, 4'b0010, 4'b0111, 4'b1110};

  sofc_top DUT (.clock, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .sample_clock_pin, .power_down_pin, .conv_data, .conv_valid, .bit_clock_out, .frame_clock_pos,
    .serial_data, .full_scale_trim, .startup_done);
  sofc_rx_model u_rx (.clock, .resetn, .bit_clock_out, .frame_clock_pos, .serial_data, .sdr,
    .fall, .wide, .word, .frames);

  initial forever #20 clock = ~clock;
  initial begin
    #7;
    forever #160 sample_clock_pin = ~sample_clock_pin;
  end

  // ********************
  // Tasks
  // ********************
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic power_up(input int edges);
    int t;
    repeat (4) @(posedge clock);
    power_down_pin <= 1'b0;
    t = 0;
    while (startup_done !== 1'b1 && t < 20000) begin
      @(negedge clock);
      t++;
    end
    chk("startup time", 16'(t >= edges * 8 - 8 && t <= edges * 8 + 24), 16'h0001);
  endtask : power_up

  task automatic wait_frames(input int n);
    int f0;
    int t;
    f0 = frames;
    t = 0;
    while (frames < f0 + n && t < 400) begin
      @(negedge clock);
      t++;
    end
    chk("frame count", 16'(frames >= f0 + n), 16'h0001);
  endtask : wait_frames

  function automatic logic [13:0] shape(input logic [12:0] c, input logic t, input logic m,
                                        input logic w);
    logic [13:0] s;
    logic [13:0] o;
    c[12] = c[12] ^ t;
    s = w ? {c, 1'b0} : {2'b00, c[12:1]};
    o = s;
    if (m) for (int j = 0; j < 14; j++) o[j] = (j < (w ? 14 : 12)) ? s[(w ? 13 : 11) - j] : 1'b0;
    return o;
  endfunction : shape

  task automatic report_and_stop;
    if (errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  // ********************
  // Tests
  // ********************
  initial begin
    #(60000 * 40);
    errors++;
    report_and_stop;
  end

  initial begin
    logic [15:0] d;
    logic [12:0] c;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    // Power down stays high meanwhile, so the word length writes are safe
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], d);
      chk("reset value", d, rv[i]);
      wr(ra[i], 16'hffff);
      @(negedge clock);
      if (i == 3) chk("trim pin", 16'(full_scale_trim), 16'h003f);
      rd(ra[i], d);
      chk("write mask", d, wm[i]);
      wr(ra[i], rv[i]);
    end
    @(posedge clock);
    for (int n = 0; n < 8; n++) conv_data[n * 13 +: 13] <= 13'h1a5b + 13'(n * 'h321);
    conv_valid <= 1'b1;
    @(posedge clock);
    conv_valid <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      @(posedge clock);
      power_down_pin <= 1'b1;
      repeat (8) @(negedge clock);
      chk("startup low", 16'(startup_done), 16'h0000);
      wr(`SOFC_ADDR_RATE, 16'(r));
      rd(`SOFC_ADDR_RATE, d);
      chk("rate class", d, 16'(r));
      power_up(cnt[r]);
    end
    for (int w = 0; w < 2; w++) begin
      if (w == 1) begin
        @(posedge clock);
        power_down_pin <= 1'b1;
        wr(`SOFC_ADDR_WLEN, {14'h0000, `SOFC_WLEN_14});
        power_up(cnt[3]);
      end
      wide <= w[0];
      for (int k = 0; k < 5; k++) begin
        wr(`SOFC_ADDR_MODE, {2'b00, cf[k][3], 8'h00, cf[k][2:0], 2'b00});
        sdr  <= cf[k][2];
        fall <= cf[k][3];
        wait_frames(4);
        for (int n = 0; n < 8; n++) begin
          c = 13'h1a5b + 13'(n * 'h321);
          chk("lane word", 16'(word[n]), 16'(shape(c, cf[k][0], cf[k][1], w[0])));
        end
        rd(`SOFC_ADDR_STATUS, d);
        chk("status", d, {12'h000, w[0], cf[k][2], 2'b11});
      end
    end
    report_and_stop;
  end
endmodule : sofc_top_bench

`default_nettype wire
